// file: logic/frc_cfg_decode.sv
`timescale 1ns/1ns
`include "frc_consts.svh"
module frc_cfg_decode (
   // Configuration word
   input  wire frc_pkg::frc_word_t cfg_in,
   // Decoded controls
   output logic       sync_mode_out,
   output logic [2:0] lat_cycles_out,
   output logic       hold_two_out,
   output logic       early_out,
   output logic       stall_pol_out,
   output logic       fall_edge_out,
   output logic [2:0] wrap_bits_out
);
   logic [2:0] lat_code;
   logic [2:0] len_code;

   always_comb begin
      lat_code = cfg_in[`FRC_LAT_HI:`FRC_LAT_LO];
      len_code = cfg_in[`FRC_LEN_HI:`FRC_LEN_LO];
      sync_mode_out = ~cfg_in[`FRC_BIT_READ_MODE];
      // Reserved latency codes fall back to the slowest legal one
      case (lat_code)
         `FRC_LAT_CODE2: lat_cycles_out = `FRC_LAT_CODE2;
         `FRC_LAT_CODE3: lat_cycles_out = `FRC_LAT_CODE3;
         default:        lat_cycles_out = `FRC_LAT_CODE4;
      endcase
      hold_two_out  = cfg_in[`FRC_BIT_HOLD];
      early_out     = cfg_in[`FRC_BIT_EARLY];
      stall_pol_out = cfg_in[`FRC_BIT_STALL_POL];
      fall_edge_out = ~cfg_in[`FRC_BIT_EDGE];
      // Only linear order exists, so the order bit steers nothing
      wrap_bits_out = 3'h0;
      if (!cfg_in[`FRC_BIT_NO_WRAP]) begin
         case (len_code)
            `FRC_LEN_4:  wrap_bits_out = 3'h2;
            `FRC_LEN_8:  wrap_bits_out = 3'h3;
            `FRC_LEN_16: wrap_bits_out = 3'h4;
            default:     wrap_bits_out = 3'h0;
         endcase
      end
   end
endmodule

// file: logic/frc_consts.svh
`ifndef FRC_CONSTS_SVH
`define FRC_CONSTS_SVH

// Command codes
`define FRC_CMD_CFG_SETUP   8'h60
`define FRC_CMD_CFG_CONFIRM 8'h03
`define FRC_CMD_READ_ID     8'h90
`define FRC_CMD_READ_ARRAY  8'hFF

// Identifier space location of the configuration word
`define FRC_ID_CFG_OFS      8'h05

// Field positions
`define FRC_BIT_READ_MODE   15
`define FRC_LAT_HI          13
`define FRC_LAT_LO          11
`define FRC_BIT_STALL_POL   10
`define FRC_BIT_HOLD        9
`define FRC_BIT_EARLY       8
`define FRC_BIT_ORDER       7
`define FRC_BIT_EDGE        6
`define FRC_BIT_NO_WRAP     3
`define FRC_LEN_HI          2
`define FRC_LEN_LO          0

// Encodings
`define FRC_LAT_CODE2       3'h2
`define FRC_LAT_CODE3       3'h3
`define FRC_LAT_CODE4       3'h4
`define FRC_LEN_4           3'h1
`define FRC_LEN_8           3'h2
`define FRC_LEN_16          3'h3
`define FRC_LEN_CONT        3'h7

// Reset value: async page, code 3, high stall, 2-clock hold, early, linear, rising, no wrap, cont
`define FRC_CFG_RESET       16'h9FCF
`endif

// file: logic/frc_pkg.sv
package frc_pkg;
   typedef enum logic [2:0] {
      FRC_ARRAY = 3'h1,
      FRC_IDENT = 3'h2,
      FRC_SETUP = 3'h4
   } frc_mode_e;
   typedef logic [15:0] frc_word_t;
endpackage

// file: logic/frc_top.sv
//Contract
// - Identifier read at location 0x05 returns the configuration word.
// - Setup 0x60 then confirm 0x03 loads address bits 15:0; reads return array.
// - Bit 15 zero selects synchronous burst; one selects async page, default.
// - Bits 13:11 give latency codes 2, 3, 4.
// - Latency counts clocks from address strobe to first data word.
// - Bit 10 sets stall output polarity; active high by default.
// - Bit 9 holds each burst word one or two clocks; two default.
// - Bit 8 releases stall one data cycle early, else with data.
// - Only linear burst order; order bit stays linear.
// - Bit 3 zero wraps inside burst length; one, default, never wraps.
// - Bits 2:0 give 4, 8, 16 words or continuous; others reserved.
`timescale 1ns/1ns
`include "frc_consts.svh"
module frc_top #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              clk_en_in,
   // Command interface
   input  wire logic              cmd_we_in,
   input  wire logic [7:0]        cmd_code_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   // Single reads
   input  wire logic              rd_req_in,
   // Burst reads
   input  wire logic              read_active_in,
   input  wire logic              address_valid_strobe_n_in,
   // Array side
   output logic      [ADDR_W-1:0] array_addr_out,
   input  wire frc_pkg::frc_word_t array_data_in,
   // Results
   output frc_pkg::frc_word_t     data_out,
   output logic                   data_valid_out,
   output logic                   stall_out,
   output logic                   seq_error_out,
   output logic                   sync_mode_out,
   output logic                   fall_edge_out,
   output frc_pkg::frc_word_t     read_configuration_out
);
   logic              rst_n_meta_r;
   logic              rst_n_sync_r;
   frc_pkg::frc_mode_e mode_r, mode_nxt;
   frc_pkg::frc_word_t cfg_r, cfg_nxt;
   frc_pkg::frc_word_t data_r, data_nxt;
   logic              dvalid_r, dvalid_nxt;
   logic              err_r, err_nxt;
   logic              busy_r, busy_nxt;
   logic [2:0]        lat_r, lat_nxt;
   logic              hold_r, hold_nxt;
   logic [ADDR_W-1:0] baddr_r, baddr_nxt;
   logic              sync_mode, hold_two, early, stall_pol;
   logic [2:0]        lat_cycles, wrap_bits;
   logic              take, stall_active;

   // Release of the reset through two flops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_n_meta_r <= 1'b0;
         rst_n_sync_r <= 1'b0;
      end else begin
         rst_n_meta_r <= 1'b1;
         rst_n_sync_r <= rst_n_meta_r;
      end
   end

   frc_cfg_decode u_dec (
      .cfg_in         (cfg_r),
      .sync_mode_out  (sync_mode),
      .lat_cycles_out (lat_cycles),
      .hold_two_out   (hold_two),
      .early_out      (early),
      .stall_pol_out  (stall_pol),
      .fall_edge_out  (fall_edge_out),
      .wrap_bits_out  (wrap_bits)
   );

   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                   input logic [2:0] wb);
      logic [ADDR_W-1:0] inc;
      logic [ADDR_W-1:0] mask;
      inc  = a + 1'b1;
      mask = (wb == 3'h0) ? '0 : ~(({{(ADDR_W-1){1'b0}}, 1'b1} << wb) - 1'b1);
      next_addr = (a & mask) | (inc & ~mask);
   endfunction

   // Command decoding and single reads
   always_comb begin
      mode_nxt   = mode_r;
      cfg_nxt    = cfg_r;
      err_nxt    = err_r;
      data_nxt   = data_r;
      dvalid_nxt = 1'b0;
      if (cmd_we_in) begin
         case (mode_r)
            frc_pkg::FRC_SETUP: begin
               mode_nxt = frc_pkg::FRC_ARRAY;
               if (cmd_code_in == `FRC_CMD_CFG_CONFIRM) begin
                  cfg_nxt = addr_in[15:0];
               end else begin
                  err_nxt = 1'b1;
               end
            end
            default: begin
               if (cmd_code_in == `FRC_CMD_CFG_SETUP) begin
                  mode_nxt = frc_pkg::FRC_SETUP;
               end else if (cmd_code_in == `FRC_CMD_READ_ID) begin
                  mode_nxt = frc_pkg::FRC_IDENT;
               end else if (cmd_code_in == `FRC_CMD_READ_ARRAY) begin
                  mode_nxt = frc_pkg::FRC_ARRAY;
                  err_nxt  = 1'b0;
               end
            end
         endcase
      end else if (rd_req_in && !busy_r) begin
         dvalid_nxt = 1'b1;
         if (mode_r == frc_pkg::FRC_IDENT) begin
            // Other identifier locations are served elsewhere and read zero here
            data_nxt = (addr_in[7:0] == `FRC_ID_CFG_OFS) ? cfg_r : 16'h0000;
         end else begin
            data_nxt = array_data_in;
         end
      end
      // Burst words take the data path over single reads
      if (busy_r && read_active_in && lat_r == 3'h0) begin
         dvalid_nxt = 1'b1;
         if (!hold_r) begin
            data_nxt = array_data_in;
         end
      end
   end

   // Burst sequencing
   assign take = !address_valid_strobe_n_in && read_active_in && !busy_r && sync_mode
                 && mode_r == frc_pkg::FRC_ARRAY && !cmd_we_in;

   always_comb begin
      busy_nxt  = busy_r;
      lat_nxt   = lat_r;
      hold_nxt  = hold_r;
      baddr_nxt = baddr_r;
      if (take) begin
         busy_nxt  = 1'b1;
         lat_nxt   = lat_cycles;
         hold_nxt  = 1'b0;
         baddr_nxt = addr_in;
      end else if (busy_r) begin
         if (!read_active_in || cmd_we_in) begin
            busy_nxt = 1'b0;
         end else if (lat_r != 3'h0) begin
            lat_nxt = 3'(lat_r - 3'h1);
         end else if (hold_two && !hold_r) begin
            hold_nxt = 1'b1;
         end else begin
            hold_nxt  = 1'b0;
            baddr_nxt = next_addr(baddr_r, wrap_bits);
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_sync_r) begin
      if (!rst_n_sync_r) begin
         mode_r   <= frc_pkg::FRC_ARRAY;
         cfg_r    <= `FRC_CFG_RESET;
         data_r   <= 16'h0000;
         dvalid_r <= 1'b0;
         err_r    <= 1'b0;
         busy_r   <= 1'b0;
         lat_r    <= 3'h0;
         hold_r   <= 1'b0;
         baddr_r  <= '0;
      end else if (clk_en_in) begin
         mode_r   <= mode_nxt;
         cfg_r    <= cfg_nxt;
         data_r   <= data_nxt;
         dvalid_r <= dvalid_nxt;
         err_r    <= err_nxt;
         busy_r   <= busy_nxt;
         lat_r    <= lat_nxt;
         hold_r   <= hold_nxt;
         baddr_r  <= baddr_nxt;
      end
   end

   // Early release drops stall a whole data cycle before the word lands
   always_comb begin
      if (!busy_r || dvalid_r) begin
         stall_active = 1'b0;
      end else if (early) begin
         stall_active = lat_r >= (hold_two ? 3'h2 : 3'h1);
      end else begin
         stall_active = 1'b1;
      end
   end

   assign stall_out              = stall_pol ? stall_active : ~stall_active;
   assign array_addr_out         = busy_r ? baddr_r : addr_in;
   assign data_out               = data_r;
   assign data_valid_out         = dvalid_r;
   assign seq_error_out          = err_r;
   assign sync_mode_out          = sync_mode;
   assign read_configuration_out = cfg_r;

   a_cfg_load_word: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      clk_en_in && cmd_we_in && mode_r == frc_pkg::FRC_SETUP
      && cmd_code_in == `FRC_CMD_CFG_CONFIRM
      |=> cfg_r == $past(addr_in[15:0]) && mode_r == frc_pkg::FRC_ARRAY)
      else $error("confirm did not load configuration");
   a_id_read_cfg: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      clk_en_in && !cmd_we_in && rd_req_in && !busy_r && mode_r == frc_pkg::FRC_IDENT
      && addr_in[7:0] == `FRC_ID_CFG_OFS |=> data_out == $past(cfg_r) && data_valid_out)
      else $error("identifier read lost configuration word");
   a_burst_only_sync: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      take |-> !cfg_r[`FRC_BIT_READ_MODE])
      else $error("burst started in async mode");
   a_latency_step: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      clk_en_in && busy_r && read_active_in && !cmd_we_in && lat_r != 3'h0
      |=> lat_r == $past(lat_r) - 3'h1)
      else $error("latency count did not step");
   a_stall_idle_level: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      !busy_r |-> stall_out == ~cfg_r[`FRC_BIT_STALL_POL])
      else $error("stall not deasserted when idle");
   a_hold_word_two: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      clk_en_in && busy_r && read_active_in && !cmd_we_in && lat_r == 3'h0
      && hold_two && !hold_r |=> baddr_r == $past(baddr_r))
      else $error("two-clock hold advanced early");
   a_stall_with_data: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      busy_r && dvalid_r |-> stall_out == ~stall_pol)
      else $error("stall asserted during valid data");
   a_wrap_four: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      clk_en_in && busy_r && read_active_in && !cmd_we_in && lat_r == 3'h0
      && wrap_bits == 3'h2 |=> baddr_r[ADDR_W-1:2] == $past(baddr_r[ADDR_W-1:2]))
      else $error("four-word burst left its block");
   a_seq_error_set: assert property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      clk_en_in && cmd_we_in && mode_r == frc_pkg::FRC_SETUP
      && cmd_code_in != `FRC_CMD_CFG_CONFIRM |=> seq_error_out)
      else $error("bad confirm not flagged");

   c_cfg_write: cover property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      clk_en_in && cmd_we_in && mode_r == frc_pkg::FRC_SETUP
      && cmd_code_in == `FRC_CMD_CFG_CONFIRM);
   c_burst_data: cover property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      busy_r && dvalid_r);
   c_wrap_seen: cover property (@(posedge clk_in) disable iff (!rst_n_sync_r)
      busy_r && wrap_bits != 3'h0 && $changed(baddr_r) && baddr_r < $past(baddr_r));
endmodule

// file: testbench/frc_host_model.sv
`timescale 1ns/1ns
module frc_host_model (
   // Clock
   input  wire logic   clk_in,
   // Command bus
   output logic        cmd_we_out,
   output logic [7:0]  cmd_code_out,
   output logic [15:0] addr_out,
   // Read controls
   output logic        rd_req_out,
   output logic        read_active_out,
   output logic        address_valid_strobe_n_out
);
   initial begin
      cmd_we_out = 1'b0;
      cmd_code_out = 8'h00;
      addr_out = 16'h0000;
      rd_req_out = 1'b0;
      read_active_out = 1'b0;
      address_valid_strobe_n_out = 1'b1;
   end
   // Released lines flip so a stale value can never pass for a new one
   task automatic req(input logic is_cmd, input logic [7:0] c, input logic [15:0] a);
      @(posedge clk_in);
      cmd_we_out <= is_cmd;
      rd_req_out <= ~is_cmd;
      cmd_code_out <= c;
      addr_out <= a;
      @(posedge clk_in);
      cmd_we_out <= 1'b0;
      rd_req_out <= 1'b0;
      cmd_code_out <= ~c;
      addr_out <= ~a;
   endtask
   // Setup and confirm back to back; dropping read active ends any burst
   task automatic cfg(input logic [15:0] w);
      logic [15:0] v;
      v = (w & 16'hBFCF) | 16'h0080;
      if (v[13:11] == 3'h2 && v[9]) v[8] = 1'b0;
      @(posedge clk_in);
      read_active_out <= 1'b0;
      cmd_we_out <= 1'b1;
      cmd_code_out <= 8'h60;
      @(posedge clk_in);
      cmd_code_out <= 8'h03;
      addr_out <= v;
      @(posedge clk_in);
      cmd_we_out <= 1'b0;
      cmd_code_out <= 8'hFC;
      addr_out <= ~v;
   endtask
   task automatic burst_go(input logic [15:0] a);
      @(posedge clk_in);
      read_active_out <= 1'b1;
      address_valid_strobe_n_out <= 1'b0;
      addr_out <= a;
      @(posedge clk_in);
      address_valid_strobe_n_out <= 1'b1;
      addr_out <= ~a;
   endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
   logic               clk_in, rst_n_in, clk_en_in, we, rd, act, stb_n;
   logic               dval, stall, serr, smode, fedge;
   logic [7:0]         code;
   logic [15:0]        addr, a_addr;
   frc_pkg::frc_word_t dout, rcfg;
   int                 fail_count, samples_checked;
   frc_host_model u_host (.clk_in(clk_in), .cmd_we_out(we), .cmd_code_out(code),
      .addr_out(addr), .rd_req_out(rd), .read_active_out(act),
      .address_valid_strobe_n_out(stb_n));
   // Array word mixes its low address byte so words differ within any 256 consecutive addresses
   frc_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
      .cmd_we_in(we), .cmd_code_in(code), .addr_in(addr), .rd_req_in(rd),
      .read_active_in(act), .address_valid_strobe_n_in(stb_n), .array_addr_out(a_addr),
      .array_data_in({~a_addr[7:0], a_addr[7:0]}), .data_out(dout), .data_valid_out(dval),
      .stall_out(stall), .seq_error_out(serr), .sync_mode_out(smode),
      .fall_edge_out(fedge), .read_configuration_out(rcfg));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d, checks %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial forever #4 clk_in = ~clk_in;
   initial begin
      repeat (3000) @(posedge clk_in);
      fail_count++;
      complete_run();
   end
   task automatic t_ident();
      u_host.req(1'b1, 8'h90, 16'h0000);
      u_host.req(1'b0, 8'h00, 16'h0005);
      @(negedge clk_in);
      chk(dout, 16'h9FCF);
      chk(16'(dval), 16'h1);
      u_host.req(1'b0, 8'h00, 16'h0004);
      @(negedge clk_in);
      chk(dout, 16'h0000);
   endtask
   // Clock enable low must freeze commands and reads alike
   task automatic t_freeze();
      @(posedge clk_in);
      clk_en_in <= 1'b0;
      u_host.cfg(16'h1ECF);
      u_host.req(1'b0, 8'h00, 16'h0034);
      @(negedge clk_in);
      chk(rcfg, 16'h1D8F);
      chk(dout, 16'hED12);
      chk(16'({dval, serr}), 16'h0);
      @(posedge clk_in);
      clk_en_in <= 1'b1;
      u_host.req(1'b1, 8'h90, 16'h0000);
      u_host.req(1'b0, 8'h00, 16'h0005);
      @(negedge clk_in);
      chk(dout, 16'h1D8F);
      chk(16'({dval, serr}), 16'h2);
   endtask
   task automatic t_cfg();
      u_host.cfg(16'h5D3F);
      @(negedge clk_in);
      chk(rcfg, 16'h1D8F);
      chk(16'({smode, fedge}), 16'h3);
      u_host.req(1'b0, 8'h00, 16'h0012);
      @(negedge clk_in);
      chk(dout, 16'hED12);
   endtask
   task automatic t_seqerr();
      u_host.req(1'b1, 8'h60, 16'h0000);
      u_host.req(1'b1, 8'h90, 16'h0001);
      @(negedge clk_in);
      chk(16'(serr), 16'h1);
      u_host.req(1'b1, 8'hFF, 16'h0000);
      @(negedge clk_in);
      chk(16'(serr), 16'h0);
   endtask
   // Wrap mask only matters for the fixed lengths
   task automatic t_burst(input logic [15:0] w, input logic [15:0] a0, input int n);
      int          lat, h;
      logic [15:0] m, ea;
      lat = int'(w[13:11]);
      h = w[9] ? 2 : 1;
      m = (w[2:0] == 3'h3) ? 16'hF : (w[2:0] == 3'h2) ? 16'h7 : 16'h3;
      u_host.cfg(w);
      u_host.burst_go(a0);
      @(negedge clk_in);
      chk(16'(stall), 16'(w[10]));
      for (int k = 1; k <= lat; k++) begin
         @(negedge clk_in);
         chk(16'(dval), 16'h0);
         if (k == lat) chk(16'(stall), 16'(w[10] ^ w[8]));
      end
      for (int k = 0; k < n; k++) begin
         @(negedge clk_in);
         ea = w[3] ? a0 + 16'(k / h) : (a0 & ~m) | ((a0 + 16'(k / h)) & m);
         chk(16'(dval), 16'h1);
         chk(16'(stall), 16'(!w[10]));
         chk(dout, {~ea[7:0], ea[7:0]});
      end
   endtask
   initial begin
      clk_in = 1'b0;
      rst_n_in = 1'b0;
      clk_en_in = 1'b1;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk(rcfg, 16'h9FCF);
      chk(16'({smode, fedge, stall, serr}), 16'h0);
      t_ident();
      t_cfg();
      t_seqerr();
      t_freeze();
      t_burst(16'h14CF, 16'h0003, 4);
      t_burst(16'h1BC1, 16'h0002, 8);
      t_burst(16'h25C2, 16'h0006, 4);
      t_burst(16'h15C3, 16'h001E, 4);
      t_burst(16'h1ECF, 16'h00FE, 4);
      complete_run();
   end
endmodule
